//--- rtl/t0sp_pkg.sv
// Constants and types for the timer with its shared scaler.
// Assumes a 200 MHz oscillator clock, four phases to one instruction cycle.
package t0sp_pkg;

  // Register addresses (9-bit data space, mirrors included)
  localparam logic [8:0] ADDR_COUNT_A = 9'h001;
  localparam logic [8:0] ADDR_COUNT_B = 9'h101;
  localparam logic [8:0] ADDR_IRQCTL_A = 9'h00B;
  localparam logic [8:0] ADDR_IRQCTL_B = 9'h08B;
  localparam logic [8:0] ADDR_IRQCTL_C = 9'h10B;
  localparam logic [8:0] ADDR_IRQCTL_D = 9'h18B;
  localparam logic [8:0] ADDR_OPTION_A = 9'h081;
  localparam logic [8:0] ADDR_OPTION_B = 9'h181;
  localparam logic [8:0] ADDR_PORTA_DIR = 9'h085;

  // Option configuration fields
  localparam int unsigned OPT_SRC_BIT = 5;
  localparam int unsigned OPT_EDGE_BIT = 4;
  localparam int unsigned OPT_ASSIGN_BIT = 3;
  localparam int unsigned RATIO_W = 3;

  // Interrupt control fields
  localparam int unsigned IC_GIE_BIT = 7;
  localparam int unsigned IC_OVF_EN_BIT = 5;
  localparam int unsigned IC_OVF_FLAG_BIT = 2;

  // Reset values and counting constants
  localparam logic [7:0] OPT_RESET = 8'hFF;
  localparam logic [7:0] IC_RESET = 8'h00;
  localparam logic [7:0] IC_KEEP_MASK = 8'h01;
  localparam logic [5:0] DIR_RESET = 6'h3F;
  localparam logic [7:0] COUNT_POR = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] SCALER_ONE = 8'h01;
  localparam logic [7:0] READ_NONE = 8'h00;

  // Oscillator phases
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  localparam logic [1:0] PHASE_STEP = 2'h1;

  // Increment hold-off after a counter write, in instruction cycles
  localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
  localparam logic [1:0] INHIBIT_STEP = 2'h1;
  localparam logic [1:0] INHIBIT_NONE = 2'h0;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } t0sp_bus_t;

  typedef struct packed {
    logic stage_a;
    logic stage_b;
  } t0sp_sync_t;

  typedef struct packed {
    logic [1:0] phase;
    logic [7:0] count;
    logic [7:0] irqctl;
    logic [7:0] option;
    logic [5:0] dir;
    logic [7:0] scaler;
    logic pol_d;
    logic sync_d;
    logic [1:0] inhibit;
    logic [7:0] rdata;
    logic irq;
    logic wdt_evt;
  } t0sp_state_t;

endpackage : t0sp_pkg

//--- rtl/t0sp_sync.sv
// Phase sampler for the scaler output.
// Assumes sample enables are one-cycle pulses on the second and fourth phase.
`timescale 1ns/100ps
`default_nettype none
module t0sp_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Sampling
  input wire logic d,
  input wire logic smp_a,
  input wire logic smp_b,
  output logic q
);

  t0sp_pkg::t0sp_sync_t s_r;
  t0sp_pkg::t0sp_sync_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (smp_a) begin
      s_nxt.stage_a = d;
    end
    if (smp_b) begin
      s_nxt.stage_b = s_r.stage_a;
    end
    if (!rstn) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  assign q = s_r.stage_b;

  a_sample_hold: assert property (@(posedge clk) disable iff (!rstn)
    !smp_a && !smp_b |=> $stable(s_r)) else $error("sampler moved off phase");

  a_second_stage: assert property (@(posedge clk) disable iff (!rstn)
    smp_b ##1 rstn |-> s_r.stage_b == $past(s_r.stage_a))
    else $error("second stage missed first");

endmodule : t0sp_sync
`default_nettype wire

//--- rtl/t0sp_top.sv
// Eight-bit timer/counter with a scaler shared with the watchdog.
// Assumes a register port with one-cycle strobes and read data a cycle later,
// a watchdog core that pulses its base tick and its clear instruction.
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module t0sp_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic POWER_ON,
  // Register port
  input wire logic [8:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // External count input
  input wire logic EXT_COUNT_INPUT,
  // Watchdog core
  input wire logic WDT_TICK,
  input wire logic WDT_CLEAR,
  output logic WDT_TIMEOUT,
  // Status
  output logic OVF_IRQ,
  output logic [5:0] PORTA_DIR
);

  t0sp_pkg::t0sp_state_t s_r;
  t0sp_pkg::t0sp_state_t s_nxt;
  t0sp_pkg::t0sp_bus_t bus;

  logic inst_tick;
  logic q2_tick;
  logic src_ext;
  logic edge_fall;
  logic to_wdt;
  logic [2:0] ratio;
  logic pol;
  logic pol_rise;
  logic ps_out;
  logic sync_q;
  logic sync_rise;
  logic [8:0] tmr_mask_w;
  logic [8:0] wdt_mask_w;
  logic [7:0] tmr_mask;
  logic [7:0] wdt_mask;
  logic tmr_term;
  logic wdt_term;
  logic scaler_evt;
  logic inc_evt;
  logic inc_ok;
  logic ovf;
  logic hit_count;
  logic hit_irqctl;
  logic hit_option;
  logic hit_dir;
  logic count_write;

  localparam logic [7:0] SCALER_INC = t0sp_pkg::SCALER_ONE;

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // Address decode
  assign hit_count = (bus.addr == t0sp_pkg::ADDR_COUNT_A)
                   || (bus.addr == t0sp_pkg::ADDR_COUNT_B);
  assign hit_irqctl = (bus.addr == t0sp_pkg::ADDR_IRQCTL_A)
                    || (bus.addr == t0sp_pkg::ADDR_IRQCTL_B)
                    || (bus.addr == t0sp_pkg::ADDR_IRQCTL_C)
                    || (bus.addr == t0sp_pkg::ADDR_IRQCTL_D);
  assign hit_option = (bus.addr == t0sp_pkg::ADDR_OPTION_A)
                    || (bus.addr == t0sp_pkg::ADDR_OPTION_B);
  assign hit_dir = (bus.addr == t0sp_pkg::ADDR_PORTA_DIR);
  assign count_write = bus.wr && hit_count;

  // Option fields
  assign src_ext = s_r.option[t0sp_pkg::OPT_SRC_BIT];
  assign edge_fall = s_r.option[t0sp_pkg::OPT_EDGE_BIT];
  assign to_wdt = s_r.option[t0sp_pkg::OPT_ASSIGN_BIT];
  assign ratio = s_r.option[t0sp_pkg::RATIO_W-1:0];

  // Phases
  assign inst_tick = (s_r.phase == t0sp_pkg::PHASE_Q4);
  assign q2_tick = (s_r.phase == t0sp_pkg::PHASE_Q2);

  // Edge polarity and prescaler output
  assign pol = EXT_COUNT_INPUT ^ edge_fall;
  assign pol_rise = pol && !s_r.pol_d;
  assign ps_out = to_wdt ? pol : s_r.scaler[ratio];

  t0sp_sync u_sync (
    .clk(CLK),
    .rstn(RSTN),
    .d(ps_out),
    .smp_a(q2_tick),
    .smp_b(inst_tick),
    .q(sync_q)
  );

  assign sync_rise = inst_tick && sync_q && !s_r.sync_d;

  // Ratio masks
  assign tmr_mask_w = (9'h002 << ratio) - 9'h001;
  assign wdt_mask_w = (9'h001 << ratio) - 9'h001;
  assign tmr_mask = tmr_mask_w[7:0];
  assign wdt_mask = wdt_mask_w[7:0];
  assign tmr_term = &(s_r.scaler | ~tmr_mask);
  assign wdt_term = &(s_r.scaler | ~wdt_mask);

  // Scaler source follows its single owner
  assign scaler_evt = to_wdt ? WDT_TICK : (src_ext ? pol_rise : inst_tick);
  assign inc_evt = src_ext ? sync_rise : (inst_tick && (to_wdt || tmr_term));
  assign inc_ok = inc_evt && (s_r.inhibit == t0sp_pkg::INHIBIT_NONE);
  assign ovf = inc_ok && (s_r.count == t0sp_pkg::COUNT_MAX) && !count_write;

  always_comb begin
    s_nxt = s_r;
    s_nxt.phase = s_r.phase + t0sp_pkg::PHASE_STEP;
    s_nxt.pol_d = pol;
    s_nxt.wdt_evt = 1'b0;
    if (inst_tick) begin
      s_nxt.sync_d = sync_q;
    end
    // Scaler count, cleared by its owner
    if (scaler_evt) begin
      s_nxt.scaler = s_r.scaler + t0sp_pkg::SCALER_ONE;
    end
    if (to_wdt && WDT_TICK && wdt_term) begin
      s_nxt.wdt_evt = 1'b1;
    end
    if (!to_wdt && count_write) begin
      s_nxt.scaler = '0;
    end
    if (to_wdt && WDT_CLEAR) begin
      s_nxt.scaler = '0;
    end
    // Increment hold-off
    if (inst_tick && (s_r.inhibit != t0sp_pkg::INHIBIT_NONE)) begin
      s_nxt.inhibit = s_r.inhibit - t0sp_pkg::INHIBIT_STEP;
    end
    if (inc_ok) begin
      s_nxt.count = s_r.count + SCALER_INC;
    end
    // Register writes
    if (bus.wr) begin
      if (hit_count) begin
        s_nxt.count = bus.wdata;
        s_nxt.inhibit = t0sp_pkg::INHIBIT_CYCLES;
      end
      if (hit_irqctl) begin
        s_nxt.irqctl = bus.wdata;
      end
      if (hit_option) begin
        s_nxt.option = bus.wdata;
      end
      if (hit_dir) begin
        s_nxt.dir = bus.wdata[5:0];
      end
    end
    // Overflow flag: set wins over a clearing write
    if (ovf) begin
      s_nxt.irqctl[t0sp_pkg::IC_OVF_FLAG_BIT] = 1'b1;
    end
    // Read data, scaler never visible
    s_nxt.rdata = t0sp_pkg::READ_NONE;
    if (bus.rd) begin
      if (hit_count) begin
        s_nxt.rdata = s_r.count;
      end else if (hit_irqctl) begin
        s_nxt.rdata = s_r.irqctl;
      end else if (hit_option) begin
        s_nxt.rdata = s_r.option;
      end else if (hit_dir) begin
        s_nxt.rdata = {2'h0, s_r.dir};
      end
    end
    s_nxt.irq = s_r.irqctl[t0sp_pkg::IC_OVF_FLAG_BIT]
              && s_r.irqctl[t0sp_pkg::IC_OVF_EN_BIT]
              && s_r.irqctl[t0sp_pkg::IC_GIE_BIT];
    // Synchronous reset
    if (!RSTN) begin
      s_nxt.phase = t0sp_pkg::PHASE_Q1;
      s_nxt.irqctl = t0sp_pkg::IC_RESET | (s_r.irqctl & t0sp_pkg::IC_KEEP_MASK);
      s_nxt.option = t0sp_pkg::OPT_RESET;
      s_nxt.dir = t0sp_pkg::DIR_RESET;
      s_nxt.scaler = '0;
      s_nxt.pol_d = pol;
      s_nxt.sync_d = 1'b0;
      // Hold-off masks a false sampler edge after reset
      s_nxt.inhibit = t0sp_pkg::INHIBIT_CYCLES;
      s_nxt.rdata = t0sp_pkg::READ_NONE;
      s_nxt.irq = 1'b0;
      s_nxt.wdt_evt = 1'b0;
      s_nxt.count = POWER_ON ? t0sp_pkg::COUNT_POR : s_r.count;
    end
  end

  always_ff @(posedge CLK) begin
    s_r <= s_nxt;
  end

  assign RDATA = s_r.rdata;
  assign OVF_IRQ = s_r.irq;
  assign WDT_TIMEOUT = s_r.wdt_evt;
  assign PORTA_DIR = s_r.dir;

  // Checks
  a_option_reset: assert property (@(posedge CLK)
    !RSTN |=> s_r.option == t0sp_pkg::OPT_RESET) else $error("option not all ones");

  a_count_kept: assert property (@(posedge CLK)
    !RSTN && !POWER_ON |=> $stable(s_r.count)) else $error("count lost on reset");

  a_write_clears: assert property (@(posedge CLK) disable iff (!RSTN)
    count_write && !to_wdt |=> s_r.scaler == '0) else $error("scaler kept on write");

  a_wdt_clears: assert property (@(posedge CLK) disable iff (!RSTN)
    WDT_CLEAR && to_wdt |=> s_r.scaler == '0) else $error("scaler kept on clear");

  a_write_holds: assert property (@(posedge CLK) disable iff (!RSTN)
    count_write ##1 !count_write [*8] |-> $stable(s_r.count))
    else $error("count moved in hold-off");

  a_internal_rate: assert property (@(posedge CLK) disable iff (!RSTN)
    inst_tick && !src_ext && to_wdt && !count_write && s_r.inhibit == 2'h0
    |=> s_r.count == $past(s_r.count) + 8'h01) else $error("missed cycle count");

  a_ext_sync: assert property (@(posedge CLK) disable iff (!RSTN)
    src_ext && inc_ok |-> sync_q && inst_tick) else $error("count before sync");

  a_passthrough: assert property (@(posedge CLK) disable iff (!RSTN)
    to_wdt |-> ps_out == (EXT_COUNT_INPUT ^ edge_fall))
    else $error("input not passed through");

  a_overflow: assert property (@(posedge CLK) disable iff (!RSTN)
    ovf |=> s_r.irqctl[t0sp_pkg::IC_OVF_FLAG_BIT] && s_r.count == 8'h00)
    else $error("overflow flag missed");

  a_mirror_read: assert property (@(posedge CLK) disable iff (!RSTN)
    bus.rd && hit_count |=> RDATA == $past(s_r.count)) else $error("mirror read wrong");

  a_tmr_divide: assert property (@(posedge CLK) disable iff (!RSTN)
    !src_ext && !to_wdt && inc_evt |-> (s_r.scaler & tmr_mask) == tmr_mask)
    else $error("ratio decode wrong");

  a_rdata_idle: assert property (@(posedge CLK) disable iff (!RSTN)
    !bus.rd |=> RDATA == t0sp_pkg::READ_NONE)
    else $error("read data not idle");

  a_unmapped_read: assert property (@(posedge CLK) disable iff (!RSTN)
    bus.rd && !(hit_count || hit_irqctl || hit_option || hit_dir)
    |=> RDATA == t0sp_pkg::READ_NONE) else $error("unmapped read not zero");

  a_irq_raise: assert property (@(posedge CLK) disable iff (!RSTN)
    s_r.irqctl[t0sp_pkg::IC_OVF_FLAG_BIT] && s_r.irqctl[t0sp_pkg::IC_OVF_EN_BIT]
    && s_r.irqctl[t0sp_pkg::IC_GIE_BIT] |=> OVF_IRQ) else $error("irq line missing");

  a_irq_mask: assert property (@(posedge CLK) disable iff (!RSTN)
    !(s_r.irqctl[t0sp_pkg::IC_OVF_FLAG_BIT] && s_r.irqctl[t0sp_pkg::IC_OVF_EN_BIT]
    && s_r.irqctl[t0sp_pkg::IC_GIE_BIT]) |=> !OVF_IRQ) else $error("irq not masked");

  a_flag_source: assert property (@(posedge CLK) disable iff (!RSTN)
    $rose(s_r.irqctl[t0sp_pkg::IC_OVF_FLAG_BIT]) && !$past(bus.wr)
    |-> $past(s_r.count) == t0sp_pkg::COUNT_MAX) else $error("flag without rollover");

  a_dir_write: assert property (@(posedge CLK) disable iff (!RSTN)
    bus.wr && hit_dir |=> PORTA_DIR == $past(WDATA[5:0]))
    else $error("direction write lost");

  a_option_write: assert property (@(posedge CLK) disable iff (!RSTN)
    bus.wr && hit_option |=> s_r.option == $past(WDATA))
    else $error("option write lost");

  a_count_write: assert property (@(posedge CLK) disable iff (!RSTN)
    count_write |=> s_r.count == $past(WDATA) && s_r.inhibit == t0sp_pkg::INHIBIT_CYCLES)
    else $error("count write lost");

  a_count_still: assert property (@(posedge CLK) disable iff (!RSTN)
    !inc_ok && !count_write |=> $stable(s_r.count))
    else $error("count moved unasked");

  a_single_step: assert property (@(posedge CLK) disable iff (!RSTN)
    inc_ok |=> !inc_ok) else $error("double increment");

  a_ext_delay: assert property (@(posedge CLK) disable iff (!RSTN)
    src_ext && inc_ok |-> !$past(sync_q, 4)) else $error("edge not synchronised");

  a_wdt_source: assert property (@(posedge CLK) disable iff (!RSTN)
    WDT_TIMEOUT |-> $past(WDT_TICK) && $past(to_wdt))
    else $error("timeout without tick");

  a_timer_owns: assert property (@(posedge CLK) disable iff (!RSTN)
    !to_wdt |=> !WDT_TIMEOUT) else $error("timeout while timer owns");

  a_reset_outputs: assert property (@(posedge CLK)
    !RSTN |=> RDATA == t0sp_pkg::READ_NONE && !OVF_IRQ && !WDT_TIMEOUT
    && PORTA_DIR == t0sp_pkg::DIR_RESET) else $error("outputs not reset");

  c_overflow: cover property (@(posedge CLK) disable iff (!RSTN) ovf);
  c_ext_count: cover property (@(posedge CLK) disable iff (!RSTN) src_ext && inc_ok);
  c_wdt_out: cover property (@(posedge CLK) disable iff (!RSTN) s_r.wdt_evt);
  c_reassign: cover property (@(posedge CLK) disable iff (!RSTN) $changed(to_wdt));

endmodule : t0sp_top
`default_nettype wire

//--- tb/t0sp_ext_src.sv
// Partner model: source of the external count clock.
// Assumes the bench calls its task; the line starts low and holds its last level between calls.
`timescale 1ns/100ps
`default_nettype none
module t0sp_ext_src (
  // Clock
  input wire logic clk,
  // Count clock
  output logic ext_out
);
  initial ext_out = 1'b0;
  // Each level held six cycles, above one instruction cycle plus margin
  task automatic level(input logic v);
    @(posedge clk);
    ext_out <= v;
    repeat (5) @(posedge clk);
  endtask : level
endmodule : t0sp_ext_src
`default_nettype wire

//--- tb/tb_t0sp_top.sv
// Testbench for the timer with its shared scaler.
// Assumes the bench plays the register master and the watchdog core.
`timescale 1ns/100ps
`default_nettype none
module tb_t0sp_top;
  logic clk, rstn, power_on, wr, rd, ext, wdt_tick, wdt_clear, wdt_to, ovf_irq;
  logic [8:0] addr;
  logic [7:0] wdata, rdata, v;
  logic [5:0] porta_dir;
  int fail_count = 0;
  int checked = 0;
  int to_cnt = 0;
  int to0, n;
  int q[$];

  t0sp_top i_t0sp_top (.CLK(clk), .RSTN(rstn), .POWER_ON(power_on), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .EXT_COUNT_INPUT(ext),
    .WDT_TICK(wdt_tick), .WDT_CLEAR(wdt_clear), .WDT_TIMEOUT(wdt_to), .OVF_IRQ(ovf_irq),
    .PORTA_DIR(porta_dir));
  t0sp_ext_src i_t0sp_ext_src (.clk(clk), .ext_out(ext));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wdt_to === 1'b1) to_cnt++;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] act);
    checked++;
    if (act !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, act);
    end
  endtask : cmp
  task automatic wreg(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic chk(input string what, input logic [8:0] a, input logic [7:0] exp,
                     input logic [7:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp(what, {8'h00, exp}, {8'h00, rdata & m});
  endtask : chk
  // Continuous reads of the count, change times kept in q
  task automatic watch(input int cyc);
    logic [7:0] last;
    q = {};
    @(posedge clk);
    addr <= t0sp_pkg::ADDR_COUNT_A;
    rd <= 1'b1;
    @(posedge clk);
    #1 last = rdata;
    for (int i = 0; i < cyc; i++) begin
      @(posedge clk);
      #1 if (rdata !== last) q.push_back(i);
      last = rdata;
    end
    @(posedge clk);
    rd <= 1'b0;
  endtask : watch
  task automatic do_reset(input logic por);
    @(posedge clk);
    power_on <= por;
    rstn <= 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
  endtask : do_reset
  task automatic wdt_pulse(input logic clr);
    @(posedge clk);
    if (clr) wdt_clear <= 1'b1;
    else wdt_tick <= 1'b1;
    @(posedge clk);
    wdt_clear <= 1'b0;
    wdt_tick <= 1'b0;
  endtask : wdt_pulse

  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    stop_test();
  end

  initial begin
    rstn = 1'b0;
    power_on = 1'b1;
    addr = 9'h000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdt_tick = 1'b0;
    wdt_clear = 1'b0;
    n = $urandom(70524);
    do_reset(1'b1);
    chk("option a", t0sp_pkg::ADDR_OPTION_A, 8'hFF, 8'hFF);
    chk("option b", t0sp_pkg::ADDR_OPTION_B, 8'hFF, 8'hFF);
    chk("irq ctl", t0sp_pkg::ADDR_IRQCTL_D, 8'h00, 8'hFE);
    chk("dir reg", t0sp_pkg::ADDR_PORTA_DIR, 8'h3F, 8'hFF);
    cmp("dir pins", 16'h003F, {10'h000, porta_dir});
    wreg(9'h002, 8'hFF);
    chk("unmapped", 9'h002, 8'h00, 8'hFF);
    v = 8'($urandom);
    wreg(t0sp_pkg::ADDR_PORTA_DIR, v);
    chk("dir write", t0sp_pkg::ADDR_PORTA_DIR, v & 8'h3F, 8'hFF);
    cmp("dir out", {10'h000, v[5:0]}, {10'h000, porta_dir});
    v = 8'($urandom);
    wreg(t0sp_pkg::ADDR_COUNT_B, v);
    chk("count mirror", t0sp_pkg::ADDR_COUNT_A, v, 8'hFF);
    wreg(t0sp_pkg::ADDR_OPTION_A, 8'h00);
    wreg(t0sp_pkg::ADDR_COUNT_A, 8'h5A);
    do_reset(1'b0);
    chk("count kept", t0sp_pkg::ADDR_COUNT_A, 8'h5A, 8'hFF);
    chk("option again", t0sp_pkg::ADDR_OPTION_B, 8'hFF, 8'hFF);
    $display("test reset done");
    wreg(t0sp_pkg::ADDR_OPTION_A, 8'h08);
    wreg(t0sp_pkg::ADDR_COUNT_B, 8'($urandom));
    watch(40);
    cmp("hold off", 16'h0001, 16'(q[0] >= 6 && q[0] <= 12));
    cmp("instr period", 16'h0004, 16'(q[1] - q[0]));
    $display("test internal done");
    wreg(t0sp_pkg::ADDR_IRQCTL_A, 8'hA0);
    wreg(t0sp_pkg::ADDR_COUNT_A, 8'hFD);
    repeat (40) @(posedge clk);
    chk("flag set", t0sp_pkg::ADDR_IRQCTL_B, 8'hA4, 8'hFE);
    cmp("irq line", 16'h0001, {15'h0000, ovf_irq});
    wreg(t0sp_pkg::ADDR_IRQCTL_C, 8'h84);
    chk("flag kept", t0sp_pkg::ADDR_IRQCTL_C, 8'h84, 8'hFE);
    cmp("irq masked", 16'h0000, {15'h0000, ovf_irq});
    wreg(t0sp_pkg::ADDR_IRQCTL_D, 8'h80);
    chk("flag clear", t0sp_pkg::ADDR_IRQCTL_A, 8'h80, 8'hFE);
    $display("test overflow done");
    for (int r = 0; r < 8; r++) begin
      wreg(t0sp_pkg::ADDR_OPTION_A, 8'(r));
      wreg(t0sp_pkg::ADDR_COUNT_A, 8'h00);
      watch((8 << r) * 3);
      cmp("ratio period", 16'(8 << r), 16'(q[1] - q[0]));
    end
    $display("test ratios done");
    for (int e = 0; e < 2; e++) begin
      i_t0sp_ext_src.level(1'b0);
      wreg(t0sp_pkg::ADDR_OPTION_A, 8'(8'h28 + 16 * e));
      wreg(t0sp_pkg::ADDR_COUNT_A, 8'h00);
      repeat (16) @(posedge clk);
      i_t0sp_ext_src.level(1'b1);
      i_t0sp_ext_src.level(1'b0);
      i_t0sp_ext_src.level(1'b1);
      repeat (16) @(posedge clk);
      chk("edge count", t0sp_pkg::ADDR_COUNT_A, 8'(2 - e), 8'hFF);
    end
    i_t0sp_ext_src.level(1'b0);
    wreg(t0sp_pkg::ADDR_OPTION_A, 8'h20);
    wreg(t0sp_pkg::ADDR_COUNT_A, 8'h00);
    repeat (16) @(posedge clk);
    n = $urandom_range(8, 1);
    repeat (n) begin
      i_t0sp_ext_src.level(1'b1);
      i_t0sp_ext_src.level(1'b0);
    end
    repeat (16) @(posedge clk);
    chk("ext scaled", t0sp_pkg::ADDR_COUNT_A, 8'((n + 1) / 2), 8'hFF);
    $display("test external done");
    wreg(t0sp_pkg::ADDR_COUNT_A, 8'h00);
    wreg(t0sp_pkg::ADDR_OPTION_A, 8'h0A);
    wdt_pulse(1'b1);
    to0 = to_cnt;
    repeat (3) wdt_pulse(1'b0);
    wdt_pulse(1'b1);
    repeat (3) wdt_pulse(1'b0);
    repeat (3) @(posedge clk);
    cmp("no timeout", 16'h0000, 16'(to_cnt - to0));
    wdt_pulse(1'b0);
    repeat (3) @(posedge clk);
    cmp("timeout", 16'h0001, 16'(to_cnt - to0));
    wdt_pulse(1'b1);
    wreg(t0sp_pkg::ADDR_OPTION_A, 8'h00);
    wreg(t0sp_pkg::ADDR_COUNT_A, 8'h00);
    watch(32);
    cmp("timer again", 16'h0008, 16'(q[1] - q[0]));
    $display("test watchdog done");
    stop_test();
  end
endmodule : tb_t0sp_top
`default_nettype wire
